/* rtl/envelope_coder_map.svh */
`ifndef ENVELOPE_CODER_MAP_SVH
`define ENVELOPE_CODER_MAP_SVH

// ----------------------------------------
// re-centring thresholds and steps
// ----------------------------------------
`define EC_HIGH_THR 17
`define EC_LOW_THR 13
`define EC_STEP_MAX 3
`define EC_CENTRE 15
`define EC_SPAN_LIMIT 11
`define EC_RESIZED_MAX 31

// ----------------------------------------
// offsets into the positive range
// ----------------------------------------
`define EC_OFFSET_BAND 32
`define EC_OFFSET_FIRST 46
`define EC_OFFSET_TRANSIENT 15
`define EC_NT_MAX 63

// ----------------------------------------
// large-symbol coding fields
// ----------------------------------------
`define EC_LS_MIN (-4)
`define EC_LS_MAX 3
`define EC_FIRST_MIN (-64)
`define EC_FIRST_MAX 63
`define EC_FIRST_BIAS 64
`define EC_FIRST_W 7
`define EC_POS_W 5
`define EC_AMP_W 7
`define EC_SHIFT_W 3
`define EC_CMD_LARGE 1'b1

// ----------------------------------------
// reset values
// ----------------------------------------
`define EC_COST_RST 16'h0000
`define EC_FIELD_RST 24'h0000_00

`endif

/* rtl/envelope_coder_pkg.sv */
package envelope_coder_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_SCAN, ST_DECIDE, ST_HEAD, ST_BODY, ST_DONE} state_t;
  typedef logic signed [9:0] wide_t;
endpackage

/* rtl/envelope_index_entropy_coder.sv */
`include "envelope_coder_map.svh"
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RULE1: high predecessor adds min(prev-17, 3)
// RULE2: low predecessor adds max(prev-13, -3)
// RULE3: resized cost sums lengths, bands one onward
// RULE4: modified index outside 0..31 disqualifies
// RULE5: span deviation from min/max around 15
// RULE6: resized allowed only below span 11
// RULE7: resized length table, symbols 5..25 only
// RULE8: pulse mode only for at most one large index after the first
// RULE9: first index beyond -64..63 forces scale
// RULE10: eight-symbol fixed large code table
// RULE11: first index escape flag, 7-bit biased
// RULE12: pulse flag, 5-bit position, 7-bit amplitude
// RULE13: header field order for large symbols
// RULE14: scale splits 3 upper, uncoded lower bits
// RULE15: smallest shift fitting range, 3-bit field
// RULE16: offsets 32/46, range 0..63 else large; transient offset 15, range 0..31
// RULE17: peel lsb then halve non-transient index
// RULE18: select resized when nonzero and not worse
// RULE19: msb first; zero length disqualifies
// RULE20: upstream holds frame until done
module envelope_index_entropy_coder #(
  parameter int MAX_BANDS = 32,
  parameter int IDX_W = 8
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // frame from the quantizer
  input wire logic start_i,
  input wire logic [5:0] band_count_i,
  input wire logic transient_frame_flag_i,
  input wire logic [MAX_BANDS*IDX_W-1:0] diff_index_i,
  input wire logic [15:0] context_cost_i,
  // mode decision
  output logic busy_o,
  output logic done_o,
  output logic resized_select_flag_o,
  output logic resized_allowed_o,
  output logic [15:0] resized_cost_o,
  output logic [15:0] best_cost_o,
  output logic large_select_o,
  output logic scale_mode_o,
  output logic [2:0] shift_o,
  output logic [MAX_BANDS-1:0] lsb_bits_o,
  // packed fields to the packer
  output logic field_valid_o,
  output logic [23:0] field_bits_o,
  output logic [4:0] field_len_o
);
  import envelope_coder_pkg::*;

  initial begin
    if (MAX_BANDS < 2 || MAX_BANDS > 32 || IDX_W < 8 || IDX_W > 9) begin
      $error("envelope coder: unsupported MAX_BANDS or IDX_W");
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic wide_t band_idx(input logic [MAX_BANDS*IDX_W-1:0] v, input logic [5:0] b);
    logic signed [IDX_W-1:0] e;
    e = v[b*IDX_W +: IDX_W];
    return wide_t'(e);
  endfunction

  function automatic logic [3:0] resized_len(input wide_t s);
    logic [3:0] l;
    l = 4'h0;
    if (s >= 10'sd5 && s <= 10'sd25) begin
      if (s == 10'sd5 || s == 10'sd25) begin // RULE7
        l = 4'hb;
      end else if (s == 10'sd6 || s == 10'sd7) begin
        l = 4'ha;
      end else if (s <= 10'sd15) begin
        l = 4'(10'sd17 - s);
      end else begin
        l = 4'(s - 10'sd14);
      end
    end
    return l;
  endfunction

  // {length, code right-aligned}
  function automatic logic [9:0] large_code(input wide_t v);
    logic [9:0] r;
    r = 10'h000;
    unique case (v[3:0]) // RULE10
      4'h0: r = {3'd1, 7'b0000001};
      4'hf: r = {3'd2, 7'b0000001};
      4'he: r = {3'd3, 7'b0000001};
      4'hd: r = {3'd5, 7'b0000011};
      4'h1: r = {3'd4, 7'b0000000};
      4'h2: r = {3'd6, 7'b0000100};
      4'h3: r = {3'd7, 7'b0001010};
      4'hc: r = {3'd7, 7'b0001011};
      default: r = 10'h000;
    endcase
    return r;
  endfunction

  function automatic logic in_small(input wide_t v);
    return v >= wide_t'(`EC_LS_MIN) && v <= wide_t'(`EC_LS_MAX);
  endfunction

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  state_t state_reg;
  logic [5:0] bidx_reg;
  logic last_band;
  assign last_band = (bidx_reg + 6'd1 >= band_count_i);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= ST_IDLE;
      bidx_reg <= 6'd0;
    end else if (ce_i) begin
      unique case (state_reg)
        ST_IDLE: if (start_i) begin // RULE20
          state_reg <= ST_SCAN;
          bidx_reg <= 6'd0;
        end
        ST_SCAN: begin
          bidx_reg <= bidx_reg + 6'd1;
          if (last_band) begin
            state_reg <= ST_DECIDE;
          end
        end
        ST_DECIDE: state_reg <= small_fail_reg ? ST_HEAD : ST_DONE;
        ST_HEAD: begin
          state_reg <= ST_BODY;
          bidx_reg <= 6'd0;
        end
        ST_BODY: begin
          bidx_reg <= bidx_reg + 6'd1;
          if (last_band) begin
            state_reg <= ST_DONE;
          end
        end
        ST_DONE: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // per-band scan
  // ----------------------------------------
  wide_t raw, off, val, modv, prev_reg, rmin_reg, rmax_reg, lmin_reg, lmax_reg, amp_reg, first_reg;
  logic [15:0] cost_reg;
  logic rs_bad_reg, small_fail_reg;
  logic [5:0] out_cnt_reg;
  logic [4:0] pos_reg;
  logic [3:0] mlen;

  always_comb begin
    raw = band_idx(diff_index_i, bidx_reg);
    if (transient_frame_flag_i) begin
      off = raw + wide_t'(`EC_OFFSET_TRANSIENT);
      val = off;
    end else begin
      off = raw + ((bidx_reg == 6'd0) ? wide_t'(`EC_OFFSET_FIRST) : wide_t'(`EC_OFFSET_BAND)); // RULE16
      val = off >>> 1; // RULE17
    end
    modv = val;
    if (prev_reg > wide_t'(`EC_HIGH_THR)) begin // RULE1
      modv = val + ((prev_reg - wide_t'(`EC_HIGH_THR) < wide_t'(`EC_STEP_MAX)) ?
                    prev_reg - wide_t'(`EC_HIGH_THR) : wide_t'(`EC_STEP_MAX));
    end else if (prev_reg < wide_t'(`EC_LOW_THR)) begin // RULE2
      modv = val + ((prev_reg - wide_t'(`EC_LOW_THR) > -wide_t'(`EC_STEP_MAX)) ?
                    prev_reg - wide_t'(`EC_LOW_THR) : -wide_t'(`EC_STEP_MAX));
    end
    mlen = resized_len(modv);
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prev_reg <= '0;
      cost_reg <= `EC_COST_RST;
      rmin_reg <= '0;
      rmax_reg <= '0;
      rs_bad_reg <= 1'b0;
      small_fail_reg <= 1'b0;
      lsb_bits_o <= '0;
    end else if (ce_i) begin
      if (state_reg == ST_IDLE && start_i) begin
        cost_reg <= `EC_COST_RST;
        rmin_reg <= wide_t'(`EC_RESIZED_MAX);
        rmax_reg <= '0;
        rs_bad_reg <= 1'b0;
        small_fail_reg <= 1'b0;
        lsb_bits_o <= '0;
      end else if (state_reg == ST_SCAN) begin
        prev_reg <= val;
        if (off < 0 || off > (transient_frame_flag_i ? wide_t'(`EC_RESIZED_MAX) : wide_t'(`EC_NT_MAX))) begin
          small_fail_reg <= 1'b1; // RULE16
        end
        if (!transient_frame_flag_i) begin
          lsb_bits_o[bidx_reg[4:0]] <= off[0]; // RULE17
        end
        if (bidx_reg != 6'd0) begin
          cost_reg <= cost_reg + 16'(mlen); // RULE3
          if (modv < rmin_reg) rmin_reg <= modv; // RULE5
          if (modv > rmax_reg) rmax_reg <= modv;
          if (modv < 0 || modv > wide_t'(`EC_RESIZED_MAX) || mlen == 4'h0) begin
            rs_bad_reg <= 1'b1; // RULE4 RULE19
          end
        end
      end
    end
  end

  // ----------------------------------------
  // large-symbol statistics
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lmin_reg <= '0;
      lmax_reg <= '0;
      out_cnt_reg <= 6'd0;
      pos_reg <= 5'd0;
      amp_reg <= '0;
      first_reg <= '0;
    end else if (ce_i) begin
      if (state_reg == ST_IDLE && start_i) begin
        lmin_reg <= '0;
        lmax_reg <= '0;
        out_cnt_reg <= 6'd0;
        pos_reg <= 5'd0;
        amp_reg <= '0;
      end else if (state_reg == ST_SCAN) begin
        if (raw < lmin_reg) lmin_reg <= raw;
        if (raw > lmax_reg) lmax_reg <= raw;
        if (bidx_reg == 6'd0) begin
          first_reg <= raw;
        end else if (!in_small(raw)) begin
          out_cnt_reg <= out_cnt_reg + 6'd1;
          pos_reg <= bidx_reg[4:0];
          amp_reg <= raw;
        end
      end
    end
  end

  // ----------------------------------------
  // mode decision
  // ----------------------------------------
  wide_t span;
  logic pulse_ok, esc, pulse;
  logic [2:0] shift_calc;
  logic [15:0] ctx_cost;
  always_comb begin
    span = (wide_t'(`EC_CENTRE) - rmin_reg > rmax_reg - wide_t'(`EC_CENTRE)) ?
           wide_t'(`EC_CENTRE) - rmin_reg : rmax_reg - wide_t'(`EC_CENTRE); // RULE5
    esc = !in_small(first_reg);
    pulse = (out_cnt_reg == 6'd1);
    pulse_ok = (out_cnt_reg <= 6'd1) // RULE8
               && first_reg >= wide_t'(`EC_FIRST_MIN) && first_reg <= wide_t'(`EC_FIRST_MAX) // RULE9
               && amp_reg >= wide_t'(`EC_FIRST_MIN) && amp_reg <= wide_t'(`EC_FIRST_MAX);
    shift_calc = 3'd7;
    for (int s = 7; s >= 0; s--) begin // RULE15
      if ((lmax_reg >>> s) <= wide_t'(`EC_LS_MAX) && (lmin_reg >>> s) >= wide_t'(`EC_LS_MIN)) begin
        shift_calc = 3'(s);
      end
    end
    ctx_cost = small_fail_reg ? 16'hffff : context_cost_i;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      resized_select_flag_o <= 1'b0;
      resized_allowed_o <= 1'b0;
      resized_cost_o <= `EC_COST_RST;
      best_cost_o <= `EC_COST_RST;
      large_select_o <= 1'b0;
      scale_mode_o <= 1'b0;
      shift_o <= 3'd0;
    end else if (ce_i && state_reg == ST_SCAN && last_band) begin
      resized_select_flag_o <= 1'b0;
      large_select_o <= 1'b0;
      scale_mode_o <= 1'b0;
      shift_o <= 3'd0;
    end else if (ce_i && state_reg == ST_DECIDE) begin
      resized_allowed_o <= !rs_bad_reg && span < wide_t'(`EC_SPAN_LIMIT) && !small_fail_reg; // RULE6
      resized_cost_o <= cost_reg;
      if (!rs_bad_reg && span < wide_t'(`EC_SPAN_LIMIT) && !small_fail_reg
          && cost_reg != 16'h0000 && cost_reg <= ctx_cost) begin // RULE18
        resized_select_flag_o <= 1'b1;
        best_cost_o <= cost_reg;
      end else begin
        resized_select_flag_o <= 1'b0;
        best_cost_o <= context_cost_i;
      end
      large_select_o <= small_fail_reg; // RULE16
      scale_mode_o <= small_fail_reg && !pulse_ok; // RULE8 RULE9
      shift_o <= (small_fail_reg && !pulse_ok) ? shift_calc : 3'd0;
    end
  end

  // ----------------------------------------
  // field emission, msb first
  // ----------------------------------------
  logic [23:0] fb;
  logic [4:0] fl;
  logic fv;
  logic [9:0] hc;
  wide_t up, biased;
  always_comb begin
    fb = `EC_FIELD_RST;
    fl = 5'd0;
    fv = 1'b0;
    up = raw >>> shift_o;
    hc = large_code(scale_mode_o ? up : raw);
    biased = first_reg + wide_t'(`EC_FIRST_BIAS);
    if (state_reg == ST_HEAD) begin // RULE13
      fv = 1'b1;
      if (scale_mode_o) begin
        fb = {19'h0_0000, `EC_CMD_LARGE, 1'b1, shift_o};
        fl = 5'd5;
      end else begin
        fb = {20'h0_0000, `EC_CMD_LARGE, 1'b0, esc, pulse}; // RULE11 RULE12
        fl = 5'd4;
        if (esc) begin
          fb = (fb << `EC_FIRST_W) | 24'(biased[`EC_FIRST_W-1:0]); // RULE11
          fl = fl + 5'd7;
        end
        if (pulse) begin
          fb = (fb << (`EC_POS_W + `EC_AMP_W)) | 24'({pos_reg, 7'(amp_reg + wide_t'(`EC_FIRST_BIAS))}); // RULE12
          fl = fl + 5'd12;
        end
      end
    end else if (state_reg == ST_BODY) begin
      if (scale_mode_o) begin // RULE14
        fv = 1'b1;
        fb = (24'(hc[6:0]) << shift_o) | (24'(raw[6:0]) & ((24'h00_0001 << shift_o) - 24'h00_0001));
        fl = 5'(hc[9:7]) + 5'(shift_o);
      end else if (!((bidx_reg == 6'd0 && esc) || (pulse && bidx_reg[4:0] == pos_reg && bidx_reg != 6'd0))) begin
        fv = 1'b1; // RULE12
        fb = 24'(hc[6:0]);
        fl = 5'(hc[9:7]);
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      field_valid_o <= 1'b0;
      field_bits_o <= `EC_FIELD_RST;
      field_len_o <= 5'd0;
    end else if (ce_i) begin
      field_valid_o <= fv; // RULE19
      field_bits_o <= fb;
      field_len_o <= fl;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else if (ce_i) begin
      busy_o <= (state_reg != ST_IDLE && state_reg != ST_DONE) || (state_reg == ST_IDLE && start_i);
      done_o <= (state_reg == ST_DONE);
    end
  end

endmodule

`default_nettype wire

/* dv/envelope_coder_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module envelope_coder_checker #(
  parameter int MAX_BANDS = 32
) (
  // clock and control
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire logic transient_frame_flag_i,
  // outputs watched
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic resized_select_flag_o,
  input wire logic [15:0] resized_cost_o,
  input wire logic [15:0] best_cost_o,
  input wire logic large_select_o,
  input wire logic scale_mode_o,
  input wire logic [2:0] shift_o,
  input wire logic [MAX_BANDS-1:0] lsb_bits_o,
  input wire logic field_valid_o,
  input wire logic [4:0] field_len_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  chk_done_one_cycle: assert property (done_o && ce_i |=> !done_o)
    else $error("done pulse held");
  chk_start_busy: assert property (start_i && ce_i && !busy_o && !done_o |=> busy_o)
    else $error("start not taken");
  chk_select_cost: assert property (resized_select_flag_o |-> resized_cost_o != 0 && best_cost_o == resized_cost_o)
    else $error("resized selection with bad cost");
  chk_large_no_resized: assert property (large_select_o |-> !resized_select_flag_o)
    else $error("resized selected with large coding");
  chk_scale_needs_large: assert property (scale_mode_o |-> large_select_o)
    else $error("scale mode outside large coding");
  chk_pulse_no_shift: assert property (!scale_mode_o |-> shift_o == 3'h0)
    else $error("shift set outside scale mode");
  chk_transient_lsb: assert property (done_o && transient_frame_flag_i |-> lsb_bits_o == '0)
    else $error("lsb bits in transient frame");
  chk_field_len: assert property (field_valid_o |-> field_len_o != 5'h00)
    else $error("empty field");
  chk_field_busy: assert property (field_valid_o |-> busy_o && !done_o)
    else $error("field outside frame");
endmodule
`default_nettype wire

/* dv/envelope_quantizer_model.sv */
`timescale 1ns/1ps
`default_nettype none
module envelope_quantizer_model #(
  parameter int W = 256
) (
  // clock and handshake
  input wire logic clk_i,
  input wire logic ce_i,
  input wire logic done_i,
  // frame to the coder
  output logic start_o,
  output logic [5:0] band_count_o,
  output logic transient_o,
  output logic [W-1:0] index_o,
  output logic [15:0] cost_o
);
  initial begin
    start_o = 1'b0;
    band_count_o = 6'h02;
    transient_o = 1'b0;
    index_o = '0;
    cost_o = 16'h0000;
  end
  // frame held from start until done
  task automatic send(input int n, input int tr, input logic [W-1:0] v, input int c);
    @(negedge clk_i);
    band_count_o = 6'(n);
    transient_o = tr[0];
    index_o = v;
    cost_o = 16'(c);
    start_o = 1'b1;
    do @(posedge clk_i); while (ce_i !== 1'b1);
    @(negedge clk_i);
    start_o = 1'b0;
    while (done_i !== 1'b1) @(negedge clk_i);
  endtask
  // released lines no longer show the frame
  task automatic drop();
    do @(posedge clk_i); while (ce_i !== 1'b1);
    @(negedge clk_i);
    index_o = ~index_o;
  endtask
endmodule
`default_nettype wire

/* dv/tb_envelope_index_entropy_coder.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_envelope_index_entropy_coder;
  logic clk_i, rst_b_i, ce_i, start_i, transient_frame_flag_i, busy_o, done_o, resized_select_flag_o;
  logic resized_allowed_o, large_select_o, scale_mode_o, field_valid_o;
  logic [5:0] band_count_i;
  logic [255:0] diff_index_i, v;
  logic [15:0] context_cost_i, resized_cost_o, best_cost_o;
  logic [2:0] shift_o;
  logic [31:0] lsb_bits_o, e_lsb, s1, s2;
  logic [23:0] field_bits_o;
  logic [4:0] field_len_o;
  int d[32];
  int hl[32] = '{0, 0, 0, 0, 0, 11, 10, 10, 9, 8, 7, 6, 5, 4, 3, 2, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 0, 0, 0, 0, 0, 0};
  int rg[5] = '{8, 8, 12, 40, 250};
  int lc[8] = '{11, 3, 1, 1, 1, 0, 4, 10};
  int ll[8] = '{7, 5, 3, 2, 1, 4, 6, 7};
  bit q_seen[$], q_exp[$];
  int n, tr, ctx, pb, err_count, checked, cyc, bad;
  int e_cost, e_large, e_allow, e_sel, e_scale, e_shift;

  envelope_index_entropy_coder u_envelope_index_entropy_coder (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .start_i(start_i), .band_count_i(band_count_i), .transient_frame_flag_i(transient_frame_flag_i),
    .diff_index_i(diff_index_i), .context_cost_i(context_cost_i), .busy_o(busy_o), .done_o(done_o),
    .resized_select_flag_o(resized_select_flag_o), .resized_allowed_o(resized_allowed_o),
    .resized_cost_o(resized_cost_o), .best_cost_o(best_cost_o), .large_select_o(large_select_o),
    .scale_mode_o(scale_mode_o), .shift_o(shift_o), .lsb_bits_o(lsb_bits_o), .field_valid_o(field_valid_o),
    .field_bits_o(field_bits_o), .field_len_o(field_len_o));
  envelope_quantizer_model u_envelope_quantizer_model (.clk_i(clk_i), .ce_i(ce_i), .done_i(done_o),
    .start_o(start_i), .band_count_o(band_count_i), .transient_o(transient_frame_flag_i),
    .index_o(diff_index_i), .cost_o(context_cost_i));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  function automatic int fits(input int s);
    fits = 1;
    for (int b = 0; b < n; b++) if ((d[b] >>> s) < -4 || (d[b] >>> s) > 3) fits = 0;
  endfunction

  // expected field bits, msb first
  function automatic void put(input int val, input int len);
    for (int i = len - 1; i >= 0; i--) q_exp.push_back(val[i]);
  endfunction

  // collect emitted field bits, one field per enabled edge
  always @(posedge clk_i) if (rst_b_i && ce_i && field_valid_o) begin
    for (int i = 23; i >= 0; i--) if (i < field_len_o) q_seen.push_back(field_bits_o[i]);
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------
  // reference model
  // ----------------------------------------
  task automatic compute();
    int a, p, m, mn, mx, cnt, pp, u;
    {e_large, e_cost, p, cnt, pp, e_lsb} = '0;
    e_allow = 1;
    mn = 99;
    mx = -99;
    for (int b = 0; b < n; b++) begin
      a = d[b] + (tr ? 15 : (b > 0 ? 32 : 46));
      if (a < 0 || a > (tr ? 31 : 63)) e_large = 1;
      if (!tr) begin
        e_lsb[b] = a[0];
        a = a >>> 1;
      end
      m = a;
      if (b > 0) begin
        if (p > 17) m += (p - 17 < 3) ? p - 17 : 3;
        if (p < 13) m += (p - 13 > -3) ? p - 13 : -3;
        if (m < 0 || m > 31 || hl[m] == 0) e_allow = 0;
        else e_cost += hl[m];
        if (m < mn) mn = m;
        if (m > mx) mx = m;
        if (d[b] < -4 || d[b] > 3) begin
          cnt += (d[b] < -64 || d[b] > 63) ? 2 : 1;
          pp = b;
        end
      end
      p = a;
    end
    if (15 - mn >= 11 || mx - 15 >= 11) e_allow = 0;
    e_sel = !e_large && e_allow && e_cost != 0 && e_cost <= ctx;
    e_scale = cnt > 1 || d[0] < -64 || d[0] > 63;
    e_shift = 0;
    if (e_scale) for (int s = 7; s >= 0; s--) if (fits(s)) e_shift = s;
    q_exp.delete();
    q_seen.delete();
    if (e_large && e_scale) begin
      put(3, 2);
      put(e_shift, 3);
      for (int b = 0; b < n; b++) begin
        u = (d[b] >>> e_shift) + 4;
        put(lc[u], ll[u]);
        put(d[b], e_shift);
      end
    end else if (e_large) begin
      put(2, 2);
      put(d[0] < -4 || d[0] > 3, 1);
      put(cnt, 1);
      if (d[0] < -4 || d[0] > 3) put(d[0] + 64, 7);
      if (cnt == 1) begin
        put(pp, 5);
        put(d[pp] + 64, 7);
      end
      for (int b = 0; b < n; b++) begin
        if (!((b == 0 && (d[0] < -4 || d[0] > 3)) || (b == pp && cnt == 1))) put(lc[d[b] + 4], ll[d[b] + 4]);
      end
    end
  endtask

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      give_verdict();
    end
  end

  always @(negedge clk_i) if (rst_b_i) begin
    s2 = xs(s2);
    ce_i = s2[2:0] != 3'h0;
  end

  initial begin
    rst_b_i = 1'b0;
    ce_i = 1'b1;
    s1 = 32'h0000_1573;
    s2 = 32'h0000_1573;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    rst_b_i = 1'b1;
    for (int f = 0; f < 60; f++) begin
      s1 = xs(s1);
      n = 2 + int'(s1 % 31);
      tr = s1[8];
      ctx = s1[15:10];
      for (int b = 0; b < 32; b++) begin
        s1 = xs(s1);
        d[b] = int'(s1 % rg[f % 5]) - rg[f % 5] / 2;
        v[b*8 +: 8] = d[b][7:0];
      end
      if (f % 5 == 1) begin
        pb = 1 + int'(s1 % (n - 1));
        d[pb] = 50;
        v[pb*8 +: 8] = 8'h32;
        if (f % 10 == 6) begin
          d[0] = -30;
          v[7:0] = 8'he2;
        end
      end
      compute();
      u_envelope_quantizer_model.send(n, tr, v, ctx);
      chk("large_select", large_select_o, e_large);
      chk("lsb_bits", lsb_bits_o, e_lsb);
      chk("select_flag", resized_select_flag_o, e_sel);
      chk("best_cost", best_cost_o, e_sel ? e_cost : ctx);
      if (!e_large) chk("allowed", resized_allowed_o, e_allow);
      if (!e_large && e_allow) chk("resized_cost", resized_cost_o, e_cost);
      if (e_large) chk("scale_mode", scale_mode_o, e_scale);
      if (e_large) chk("shift", shift_o, e_shift);
      bad = 0;
      for (int i = 0; i < q_exp.size() && i < q_seen.size(); i++) if (q_seen[i] != q_exp[i]) bad++;
      chk("field_count", q_seen.size(), q_exp.size());
      chk("field_bits", bad, 0);
      u_envelope_quantizer_model.drop();
    end
    give_verdict();
  end
endmodule

bind envelope_index_entropy_coder envelope_coder_checker #(.MAX_BANDS(MAX_BANDS)) u_envelope_coder_checker (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .start_i(start_i),
  .transient_frame_flag_i(transient_frame_flag_i), .busy_o(busy_o), .done_o(done_o),
  .resized_select_flag_o(resized_select_flag_o), .resized_cost_o(resized_cost_o), .best_cost_o(best_cost_o),
  .large_select_o(large_select_o), .scale_mode_o(scale_mode_o), .shift_o(shift_o), .lsb_bits_o(lsb_bits_o),
  .field_valid_o(field_valid_o), .field_len_o(field_len_o));
`default_nettype wire
